// ---- prh_pkg.sv ----
package prh_pkg;
  // clock and timeout
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SA_TIMEOUT_NS = 2048;
  localparam int unsigned SA_TIMEOUT_CYC = (SA_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMO_W = 9;
  // data and inbound read fifo
  localparam int DATA_W = 32;
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [FIFO_AW:0] READ_REFILL_THRESHOLD = 5'h08;
  localparam logic [FIFO_AW:0] FIFO_STOP_LEVEL = 5'h0e;
  localparam logic [FIFO_AW:0] FIFO_FULL_LEVEL = 5'h10;
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIMIT_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] PSTAT_OFS = 8'h0c;
  localparam logic [7:0] STATE_OFS = 8'h10;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int FLAG_SERR_BIT = 0;
  localparam int FLAG_PERR_BIT = 1;
  localparam int FLAG_TABORT_BIT = 2;
  localparam int PSTAT_PERR_BIT = 0;
  localparam int STATE_CNT_LSB = 0;
  localparam int STATE_PST_LSB = 8;
  // reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [31:0] LIMIT_RST = 32'hffff_fffc;
  // error event kinds carried over the handshake
  localparam int EV_SERR = 0;
  localparam int EV_PERR = 1;
  localparam int EV_TABORT = 2;
  localparam int EV_MABORT = 3;
  localparam int EV_STOP = 4;
  localparam int EV_W = 5;

  typedef enum logic [4:0] {
    P_IDLE = 5'h01,
    P_REQ = 5'h02,
    P_XFER = 5'h04,
    P_WAIT = 5'h08,
    P_HALT = 5'h10
  } prh_pstate_t;

  // pins from the pci initiator core, all in the pci clock domain
  typedef struct packed {
    logic clk;
    logic busy;
    logic valid;
    logic cend;
    logic retry;
    logic mabort;
    logic tabort;
    logic perr;
    logic serr;
    logic [DATA_W-1:0] data;
  } prh_pins_t;
endpackage : prh_pkg

// ---- prh_fifo_if.sv ----
`timescale 1ns/1ns
interface prh_fifo_if;
  import prh_pkg::*;
  logic we;
  logic [FIFO_AW-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic re;
  logic [FIFO_AW-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : prh_fifo_if

// ---- prh_sync.sv ----
`timescale 1ns/1ns
module prh_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // local clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] async_in, // pins from the pci domain
  output logic [W-1:0] sync_out // two-stage synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } prh_sync_st_t;
  prh_sync_st_t r;
  prh_sync_st_t n;

  // first stage feeds only the second
  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;
endmodule : prh_sync

// ---- prh_fifo_mem.sv ----
`timescale 1ns/1ns
module prh_fifo_mem (
  input wire logic pclk, // local clock
  input wire logic presetn, // async reset, active low
  prh_fifo_if.store m // write and read ports
);
  import prh_pkg::*;
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0] rd;
  } prh_mem_st_t;
  prh_mem_st_t r;
  prh_mem_st_t n;

  // write a word, read into the output register
  always_comb begin
    n = r;
    if (m.we) begin
      n.mem[m.waddr] = m.wdata;
    end
    if (m.re) begin
      n.rd = r.mem[m.raddr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign m.rdata = r.rd;
endmodule : prh_fifo_mem

// ---- prh_read_err.sv ----
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ns
module prh_read_err (
  input wire logic pclk, // local bus clock, 125 MHz
  input wire logic presetn, // async reset, active low
  // apb register port
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 = write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  // local bus read request from the slave attachment
  input wire logic lb_req, // read request, level, held by master
  input wire logic lb_burst, // read_burst_qualifier, burst or cacheline
  input wire logic [31:0] lb_addr, // translated pci read address
  output logic lb_rd_ack, // one word delivered, pulse
  output logic [31:0] lb_rd_data, // word delivered with lb_rd_ack
  output logic slave_error_response, // timeout error response, pulse
  output logic lb_rearbitrate, // retry reported to master, pulse
  // pci initiator core, pci clock domain
  input wire logic pci_clk, // pci clock, sampled
  input wire logic pci_busy, // core has taken the read request
  input wire logic pci_valid, // data word valid this pci cycle
  input wire logic [31:0] pci_data, // read data word
  input wire logic pci_cend, // pci cycle ends this pci cycle
  input wire logic pci_retry, // end code: retry, no data
  input wire logic pci_mabort, // end code: master abort
  input wire logic pci_tabort, // end code: target abort
  input wire logic pci_perr, // data parity error seen
  input wire logic pci_serr, // system error seen
  output logic pci_rd_req, // read request to the core, level
  output logic [31:0] pci_rd_addr, // read address to the core
  output logic pci_rd_burst, // memory read multiple when high
  output logic pci_rd_stop // ask the core to end the cycle
);
  import prh_pkg::*;

  typedef struct packed {
    // pci facing side
    prh_pstate_t pst;
    logic [31:0] addr;
    logic burst;
    logic first;
    logic got;
    logic txn_open;
    logic req_o;
    logic stop_o;
    logic rearb;
    logic [EV_W-1:0] ev_pend;
    logic hs_req;
    logic [EV_W-1:0] hs_kind;
    logic clk_prev;
    // local side
    logic hs_ack;
    logic [FIFO_AW-1:0] wptr;
    logic [FIFO_AW-1:0] rptr;
    logic [FIFO_AW:0] count;
    logic pop_d;
    logic served;
    logic blocked;
    logic err_seen;
    logic [TMO_W-1:0] tmo;
    logic ack;
    logic [31:0] data;
    logic slv_err;
    // registers
    logic ctrl_en;
    logic [31:0] limit;
    logic [2:0] flags;
    logic perr_stat;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } prh_top_st_t;

  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(SA_TIMEOUT_CYC - 1);

  prh_top_st_t r;
  prh_top_st_t n;
  prh_pins_t pin;
  logic [$bits(prh_pins_t)-1:0] pin_raw;
  logic wr;
  logic pop;
  logic flush;
  logic pe;
  logic over;
  logic refetching;
  logic deliver_ok;
  logic setup;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] pend;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [31:0] rdmux;
  logic rd_hit;

  prh_fifo_if fif ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and inbound read fifo storage
  prh_sync #(
    .W($bits(prh_pins_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pci_clk, pci_busy, pci_valid, pci_cend, pci_retry, pci_mabort,
               pci_tabort, pci_perr, pci_serr, pci_data}),
    .sync_out(pin_raw)
  );

  assign pin = prh_pins_t'(pin_raw);

  prh_fifo_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .m(fif.store)
  );

  assign fif.we = wr;
  assign fif.waddr = r.wptr;
  assign fif.wdata = pin.data;
  assign fif.re = pop;
  assign fif.raddr = r.rptr;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    ev = '0;
    wr = 1'b0;
    n.rearb = 1'b0;
    n.ack = 1'b0;
    n.slv_err = 1'b0;
    // rising edge of the synchronised pci clock
    pe = pin.clk & ~r.clk_prev;
    n.clk_prev = pin.clk;
    over = r.addr > r.limit;

    // pci side sequencer, advances once per pci clock
    if (pe) begin
      case (r.pst)
        P_IDLE: begin
          if (lb_req && !r.txn_open && r.ctrl_en) begin
            n.txn_open = 1'b1;
            n.addr = {lb_addr[31:2], 2'b00};
            n.burst = lb_burst;
            n.first = 1'b1;
            n.got = 1'b0;
            if ({lb_addr[31:2], 2'b00} > r.limit) begin
              ev[EV_STOP] = 1'b1;
              n.pst = P_HALT;
            end else begin
              n.pst = P_REQ;
            end
          end
        end
        P_REQ: begin
          if (pin.busy) begin
            n.pst = P_XFER;
          end
        end
        P_XFER: begin
          // data past the last valid address is never buffered
          if (pin.valid && !over && r.count < FIFO_FULL_LEVEL) begin
            wr = 1'b1;
            n.addr = r.addr + 32'h4;
            n.got = 1'b1;
            n.first = 1'b0;
          end
          // single read parity error keeps the data
          if (pin.perr && pin.valid && !r.burst) begin
            ev[EV_PERR] = 1'b1;
          end
          if (pin.serr) begin
            ev[EV_SERR] = 1'b1;
            n.pst = P_HALT;
          end else if (pin.perr && r.burst) begin
            wr = 1'b0;
            n.addr = r.addr;
            ev[EV_PERR] = 1'b1;
            ev[EV_STOP] = 1'b1;
            n.pst = P_HALT;
          end else if (pin.cend) begin
            if (pin.tabort) begin
              ev[EV_TABORT] = 1'b1;
              ev[EV_STOP] = 1'b1;
              n.pst = P_HALT;
            end else if (pin.mabort) begin
              ev[EV_MABORT] = 1'b1;
              n.pst = P_HALT;
            end else if (pin.retry) begin
              n.rearb = 1'b1;
              n.pst = (!r.burst || r.first) ? P_REQ : P_WAIT;
            end else if (!r.burst) begin
              // a single read ends once a word has arrived
              n.pst = (r.got || wr) ? P_IDLE : P_REQ;
            end else begin
              // disconnect, latency expiry or fifo stop in a burst
              n.pst = P_WAIT;
            end
          end
        end
        P_WAIT: begin
          if (!lb_req) begin
            n.pst = P_IDLE;
          end else if (r.count < READ_REFILL_THRESHOLD && !over) begin
            n.pst = P_REQ;
          end
        end
        P_HALT: begin
          if (!lb_req) begin
            n.pst = P_IDLE;
          end
        end
        default: begin
          n.pst = P_IDLE;
        end
      endcase
    end
    if (!lb_req) begin
      n.txn_open = 1'b0;
    end
    n.req_o = n.pst == P_REQ;
    n.stop_o = (n.pst == P_XFER) && n.burst &&
               (n.count >= FIFO_STOP_LEVEL || n.addr > n.limit || !lb_req);

    // pci side of the event handshake
    pend = r.ev_pend | ev;
    if (r.hs_req && r.hs_ack) begin
      n.hs_req = 1'b0;
    end else if (!r.hs_req && !r.hs_ack && pend != '0) begin
      n.hs_req = 1'b1;
      n.hs_kind = pend;
      pend = '0;
    end
    n.ev_pend = pend;

    // local side of the event handshake
    flag_set = '0;
    if (r.hs_req && !r.hs_ack) begin
      n.hs_ack = 1'b1;
      flag_set[FLAG_SERR_BIT] = r.hs_kind[EV_SERR];
      flag_set[FLAG_PERR_BIT] = r.hs_kind[EV_PERR];
      flag_set[FLAG_TABORT_BIT] = r.hs_kind[EV_TABORT];
      n.blocked = r.blocked | r.hs_kind[EV_STOP];
      n.err_seen = r.err_seen | r.hs_kind[EV_SERR] | r.hs_kind[EV_TABORT] |
                   r.hs_kind[EV_MABORT] | r.hs_kind[EV_STOP];
    end else if (!r.hs_req) begin
      n.hs_ack = 1'b0;
    end
    if (!lb_req) begin
      n.blocked = 1'b0;
      n.err_seen = 1'b0;
      n.served = 1'b0;
    end

    // local delivery from the fifo, one word every other cycle
    deliver_ok = lb_req && !r.blocked && !(!r.burst && r.served);
    flush = !lb_req && r.pst != P_REQ && r.pst != P_XFER;
    pop = deliver_ok && r.count != '0 && !r.pop_d;
    n.pop_d = pop;
    if (r.pop_d) begin
      n.ack = 1'b1;
      n.data = fif.rdata;
      n.served = 1'b1;
    end
    if (flush) begin
      n.wptr = '0;
      n.rptr = '0;
      n.count = '0;
    end else begin
      n.wptr = r.wptr + FIFO_AW'(wr);
      n.rptr = r.rptr + FIFO_AW'(pop);
      n.count = r.count + (FIFO_AW + 1)'(wr) - (FIFO_AW + 1)'(pop);
    end

    // slave-attachment timeout, held off while still fetching
    refetching = r.ctrl_en && !r.err_seen &&
                 (r.pst == P_REQ || r.pst == P_XFER || (r.pst == P_WAIT && !over));
    if (!lb_req || r.pop_d || refetching) begin
      n.tmo = '0;
    end else if (r.tmo == TMO_LAST) begin
      n.tmo = '0;
      n.slv_err = 1'b1;
    end else begin
      n.tmo = r.tmo + TMO_W'(1);
    end

    // apb read mux
    rd_hit = 1'b1;
    rdmux = '0;
    case (paddr)
      CTRL_OFS: rdmux[CTRL_EN_BIT] = r.ctrl_en;
      LIMIT_OFS: rdmux = r.limit;
      FLAG_OFS: rdmux[2:0] = r.flags;
      PSTAT_OFS: rdmux[PSTAT_PERR_BIT] = r.perr_stat;
      STATE_OFS: begin
        rdmux[STATE_CNT_LSB +: FIFO_AW + 1] = r.count;
        rdmux[STATE_PST_LSB +: 5] = r.pst;
      end
      default: rd_hit = 1'b0;
    endcase

    // apb slave: one wait cycle, access taken when pready is high
    setup = psel && penable && !r.pready;
    n.pready = setup;
    if (setup) begin
      n.prdata = pwrite ? 32'h0 : rdmux;
      n.pslverr = !rd_hit;
    end
    flag_clr = '0;
    if (psel && penable && r.pready && pwrite && rd_hit) begin
      case (paddr)
        CTRL_OFS: n.ctrl_en = pwdata[CTRL_EN_BIT];
        LIMIT_OFS: n.limit = {pwdata[31:2], 2'b00};
        FLAG_OFS: flag_clr = pwdata[2:0];
        PSTAT_OFS: begin
          if (pwdata[PSTAT_PERR_BIT]) begin
            n.perr_stat = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    n.flags = (r.flags & ~flag_clr) | flag_set;
    if (flag_set[FLAG_PERR_BIT]) begin
      n.perr_stat = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pst <= P_IDLE;
      r.ctrl_en <= CTRL_EN_RST;
      r.limit <= LIMIT_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign lb_rd_ack = r.ack;
  assign lb_rd_data = r.data;
  assign slave_error_response = r.slv_err;
  assign lb_rearbitrate = r.rearb;
  assign pci_rd_req = r.req_o;
  assign pci_rd_addr = r.addr;
  assign pci_rd_burst = r.burst;
  assign pci_rd_stop = r.stop_o;
endmodule : prh_read_err

// ---- prh_read_err_chk.sv ----
`timescale 1ns/1ns
////////////////////////////////////////
module prh_read_err_chk import prh_pkg::*; (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic penable, // apb access
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic lb_req, // local request
  input wire logic lb_burst, // burst qualifier
  input wire logic lb_rd_ack, // word ack
  input wire logic slave_error_response, // timeout error
  input wire logic lb_rearbitrate, // retry report
  input wire logic pci_retry, // retry code
  input wire logic pci_busy, // core took request
  input wire logic pci_rd_req, // core request
  input wire logic [31:0] pci_rd_addr // core address
);
  logic [9:0] idle_cnt;
  logic [5:0] since_rty;
  logic got_ack;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // cycles waited without an ack, time since a retry, ack already given
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= 10'h000;
      since_rty <= 6'h3f;
      got_ack <= 1'b0;
    end else begin
      idle_cnt <= (!lb_req || lb_rd_ack) ? 10'h000 : idle_cnt + 10'h001;
      since_rty <= pci_retry ? 6'h00 : ((since_rty == 6'h3f) ? since_rty : since_rty + 6'h01);
      got_ack <= lb_req && (got_ack || lb_rd_ack);
    end
  end
  // apb access: one wait state, then ready for one cycle
  sequence acc_s;
    !pready ##1 pready ##1 !pready;
  endsequence
  apb_wait_a: assert property ($rose(penable) |-> acc_s) else $error("apb answer timing wrong");
  apb_decode_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr[7:2] > 6'h04))
    else $error("apb decode wrong");
  apb_refuse_a: assert property (pready && pslverr |-> prdata == 32'h0) else $error("unmapped data not zero");
  ack_gap_a: assert property (lb_rd_ack |=> !lb_rd_ack) else $error("acks too close");
  ack_cause_a: assert property (lb_rd_ack |-> $past(lb_req, 2)) else $error("ack without request");
  single_once_a: assert property (lb_rd_ack && !lb_burst |-> !got_ack)
    else $error("second ack on single read");
  tmo_len_a: assert property (slave_error_response |-> idle_cnt >= SA_TIMEOUT_CYC - 4 ##1 !slave_error_response)
    else $error("timeout too early");
  rearb_cause_a: assert property (lb_rearbitrate |-> since_rty < 6'd40 ##1 !lb_rearbitrate)
    else $error("rearbitrate without retry");
  req_hold_a: assert property ($fell(pci_rd_req) |-> $past(pci_busy)) else $error("request dropped early");
  addr_align_a: assert property (pci_rd_req |-> pci_rd_addr[1:0] == 2'b00) else $error("address not aligned");
endmodule : prh_read_err_chk
bind prh_read_err prh_read_err_chk prh_read_err_chk_inst (.pclk(pclk), .presetn(presetn), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lb_req(lb_req), .lb_burst(lb_burst),
  .lb_rd_ack(lb_rd_ack), .slave_error_response(slave_error_response), .lb_rearbitrate(lb_rearbitrate),
  .pci_retry(pci_retry), .pci_busy(pci_busy), .pci_rd_req(pci_rd_req), .pci_rd_addr(pci_rd_addr));

// ---- prh_pci_model.sv ----
`timescale 1ns/1ns
////////////////////////////////////////
module prh_pci_model (
  input wire logic lb_req, // rearms the one-shot retry
  input wire logic [2:0] mode, // 0 ok 1 retry 2 mabort 3 tabort 4 perr 5 serr
  input wire logic [3:0] nw, // words per pci cycle
  input wire logic pci_rd_req, // request
  input wire logic [31:0] pci_rd_addr, // start address
  input wire logic pci_rd_stop, // end cycle early
  output logic pci_clk, // free running
  output logic pci_busy, // request taken
  output logic pci_valid, // word valid
  output logic [31:0] pci_data, // word
  output logic pci_cend, // cycle end
  output logic pci_retry, // end code
  output logic pci_mabort, // end code
  output logic pci_tabort, // end code
  output logic pci_perr, // parity error
  output logic pci_serr // system error
);
  logic [31:0] a;
  logic [3:0] n;
  logic rdone;
  // pci clock, phase unrelated to pclk
  initial begin
    pci_clk = 1'b0;
    #3;
    forever #80 pci_clk = ~pci_clk;
  end
  // idle values at time zero
  initial begin
    {pci_busy, pci_valid, pci_cend, pci_retry, pci_mabort, pci_tabort, pci_perr, pci_serr} = 8'h00;
    pci_data = 32'h0;
    rdone = 1'b0;
  end
  // outputs move on the falling edge so they are stable at the rising one
  always @(negedge pci_clk) begin
    {pci_valid, pci_cend, pci_retry, pci_mabort, pci_tabort, pci_perr, pci_serr} <= 7'h00;
    pci_data <= ~pci_data; // data lines keep changing when not valid
    if (!lb_req)
      rdone <= 1'b0;
    if (!pci_busy) begin
      pci_busy <= pci_rd_req;
      a <= pci_rd_addr;
      n <= 4'h0;
    end else if (mode == 3'h1 && !rdone) begin
      {pci_cend, pci_retry, pci_busy, rdone} <= 4'b1101;
    end else if (mode inside {3'h2, 3'h3, 3'h5}) begin
      pci_cend <= 1'b1;
      pci_mabort <= mode == 3'h2;
      pci_tabort <= mode == 3'h3;
      pci_serr <= mode == 3'h5;
      pci_busy <= 1'b0;
    end else begin
      pci_valid <= 1'b1;
      pci_data <= a;
      pci_perr <= mode == 3'h4 && n == nw - 4'h1;
      a <= a + 32'h4;
      n <= n + 4'h1;
      pci_cend <= n == nw - 4'h1 || pci_rd_stop;
      pci_busy <= !(n == nw - 4'h1 || pci_rd_stop);
    end
  end
endmodule : prh_pci_model

// ---- prh_read_err_tb_top.sv ----
`timescale 1ns/1ns
////////////////////////////////////////
module prh_read_err_tb_top;
  import prh_pkg::*;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lb_req = 1'b0, lb_burst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, lb_addr = 32'h0, prdata, lb_rd_data, pci_data, pci_rd_addr;
  logic pready, pslverr, lb_rd_ack, slave_error_response, lb_rearbitrate, pci_rd_req, pci_rd_burst, pci_rd_stop;
  logic pci_clk, pci_busy, pci_valid, pci_cend, pci_retry, pci_mabort, pci_tabort, pci_perr, pci_serr;
  logic [2:0] mode = 3'h0;
  logic [3:0] nw = 4'h1;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  // mode, words per cycle, burst, wanted, acks (-1 any), error, flags, parity status, rearbitrate
  int tbl [9][9] = '{'{0, 1, 0, 1, 1, 0, 0, 0, 0}, '{1, 1, 0, 1, 1, 0, 0, 0, 1}, '{2, 1, 0, 1, 0, 1, 0, 0, 0},
    '{3, 1, 0, 1, 0, 1, 4, 0, 0}, '{4, 1, 0, 1, 1, 0, 2, 1, 0}, '{5, 1, 0, 1, 0, 1, 1, 0, 0},
    '{0, 4, 1, 12, 12, 0, 0, 0, 0}, '{4, 4, 1, 12, -1, 1, 2, 1, 0}, '{1, 4, 1, 12, 12, 0, 0, 0, 1}};
  prh_read_err prh_read_err_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lb_req(lb_req), .lb_burst(lb_burst), .lb_addr(lb_addr), .lb_rd_ack(lb_rd_ack), .lb_rd_data(lb_rd_data),
    .slave_error_response(slave_error_response), .lb_rearbitrate(lb_rearbitrate), .pci_clk(pci_clk),
    .pci_busy(pci_busy), .pci_valid(pci_valid), .pci_data(pci_data), .pci_cend(pci_cend),
    .pci_retry(pci_retry), .pci_mabort(pci_mabort), .pci_tabort(pci_tabort), .pci_perr(pci_perr),
    .pci_serr(pci_serr), .pci_rd_req(pci_rd_req), .pci_rd_addr(pci_rd_addr), .pci_rd_burst(pci_rd_burst),
    .pci_rd_stop(pci_rd_stop));
  prh_pci_model prh_pci_model_inst (.lb_req(lb_req), .mode(mode), .nw(nw), .pci_rd_req(pci_rd_req),
    .pci_rd_addr(pci_rd_addr), .pci_rd_stop(pci_rd_stop), .pci_clk(pci_clk), .pci_busy(pci_busy),
    .pci_valid(pci_valid), .pci_data(pci_data), .pci_cend(pci_cend), .pci_retry(pci_retry),
    .pci_mabort(pci_mabort), .pci_tabort(pci_tabort), .pci_perr(pci_perr), .pci_serr(pci_serr));
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, ad, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, ad, 32'h0, q, e);
    chk(q, x, "register read");
  endtask : rdc
  // local read: hold the request until enough words or an error, then idle
  task automatic lbr(input logic b, input logic [31:0] a, input int want, output int acks, output int errs,
    output int rearb);
    acks = 0;
    errs = 0;
    rearb = 0;
    @(posedge pclk);
    lb_req <= 1'b1;
    lb_burst <= b;
    lb_addr <= a;
    for (int i = 0; i < 1500 && errs == 0 && acks < want; i++) begin
      @(posedge pclk);
      if (lb_rd_ack === 1'b1) begin
        chk(lb_rd_data, a + 32'(4 * acks), "read data");
        acks++;
      end
      errs += int'(slave_error_response === 1'b1);
      rearb += int'(lb_rearbitrate === 1'b1);
      if (pci_rd_req === 1'b1) begin
        chk(pci_rd_burst, b, "burst qualifier");
      end
    end
    lb_req <= 1'b0;
    repeat (60) begin
      @(posedge pclk);
      acks += int'(lb_rd_ack === 1'b1 && !b);
      errs += int'(slave_error_response === 1'b1);
      rearb += int'(lb_rearbitrate === 1'b1);
    end
  endtask : lbr
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // main sequence
  initial begin
    int acks, errs, rearb;
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CTRL_OFS, 32'h1);
    rdc(LIMIT_OFS, LIMIT_RST);
    rdc(FLAG_OFS, 32'h0);
    rdc(STATE_OFS, 32'h0000_0100);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(e, 1'b1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    $display("test registers done");
    for (int k = 0; k < 9; k++) begin
      mode <= 3'(tbl[k][0]);
      nw <= 4'(tbl[k][1]);
      lbr(tbl[k][2] != 0, 32'h1000 + 32'(k * 256), tbl[k][3], acks, errs, rearb);
      if (tbl[k][4] >= 0)
        chk(acks, tbl[k][4], "acks");
      chk(errs, tbl[k][5], "error response");
      chk(rearb, tbl[k][8], "rearbitrate");
      rdc(FLAG_OFS, tbl[k][6]);
      rdc(PSTAT_OFS, tbl[k][7]);
      wr(FLAG_OFS, 32'h7);
      wr(PSTAT_OFS, 32'h1);
      rdc(FLAG_OFS, 32'h0);
      $display("test %0d done", k);
    end
    // burst into the address limit, then reads disabled
    wr(LIMIT_OFS, 32'h2014);
    mode <= 3'h0;
    nw <= 4'h4;
    lbr(1'b1, 32'h2000, 12, acks, errs, rearb);
    chk(acks, 6, "acks to limit");
    chk(errs, 1, "error after drain");
    wr(LIMIT_OFS, LIMIT_RST);
    wr(CTRL_OFS, 32'h0);
    lbr(1'b0, 32'h3000, 1, acks, errs, rearb);
    chk(errs, 1, "error when disabled");
    wr(CTRL_OFS, 32'h1);
    $display("test limit and enable done");
    final_report();
  end
endmodule : prh_read_err_tb_top
